/* verilog/host_port_pkg.sv */
// package of constants for the host bus attachment port
// ----------------------------------------------------------------------------
// Behaviour
// - address strobe is driven during the address phase of every master cycle
// - latch polarity bit 1: 0 gives high strobe, 1 gives inverted strobe
// - while arbitrating, address strobe is an input; only style 01 watches it for idle
// - style 01: after grant, claim only if claim, data and address strobes idle
// - style 01: mastership claim stays asserted while device owns the bus
// - style 00: master indication asserted whenever the device owns the bus
// - slave cycles: port kind 0 is data port, 1 is register address port
// - port kind input is ignored while the device is bus master
// - register access needs chip select with port kind; select ignored as master
// - collision input used only when serial port choice bit 8 picks external port
// - style 00: low two lines carry bank selects in address, data after
// - style 01: low two lines carry byte offset in address, data after
// - lines 2 to 31 carry the address, then data in the data phase
// - slave cycles use all lines as plain multiplexed lines
// - inbound transceiver enable opens the path toward the device
// - outbound transceiver enable opens the path away from the device
// - data strobe is output as master, input as slave
// - style 00: request dropped within five cycles once hold grant is removed
// - master waits for low acknowledge; slave leaves it released for wait states, then drives it low
// ----------------------------------------------------------------------------
package host_port_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] WDATA_OFFSET = 8'h0c;
  localparam logic [7:0] RDATA_OFFSET = 8'h10;
  localparam logic [7:0] STATUS_OFFSET = 8'h14;
  localparam logic [7:0] SLV_ADDR_OFFSET = 8'h18;
  localparam logic [7:0] SLV_DATA_OFFSET = 8'h1c;
  // control register fields
  localparam int LATCH_POL_POS = 1;
  localparam int STYLE_LSB = 4;
  localparam int PORT_CHOICE_POS = 8;
  localparam int BANK_SEL_LSB = 12;
  // command register fields
  localparam int CMD_START_POS = 0;
  localparam int CMD_WRITE_POS = 1;
  // status register fields
  localparam int ST_BUSY_POS = 0;
  localparam int ST_OWNER_POS = 1;
  localparam int ST_COLL_POS = 2;
  localparam int ST_CARRIER_POS = 3;
  localparam int ST_STATE_LSB = 4;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  // timing
  localparam int CLK_MHZ = 40;
  localparam int SLAVE_WAIT_NS = 25;
  localparam int SLAVE_WAIT_CYCLES = (SLAVE_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_PINS = 41;

  typedef enum logic [1:0] {
    STYLE_HOLD = 2'b00,
    STYLE_GRANT = 2'b01
  } bus_style_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_DONE = 3'b100
  } master_state_e;
endpackage

/* verilog/pin_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_level,
  output logic [WIDTH-1:0] sync_out
);
  // ----------------------------------------------------------------------------
  // two stages per bit
  // ----------------------------------------------------------------------------
  initial begin
    if (WIDTH < 1) $error("pin_sync width must be at least one");
  end

  // flops hold the pin relative to its idle level: a plain zero reset then
  // shows every output at its idle level, with no false edge after release
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage_one_reg;
      logic stage_two_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_one_reg <= 1'b0;
          stage_two_reg <= 1'b0;
        end else begin
          stage_one_reg <= async_in[i] ^ reset_level[i];
          stage_two_reg <= stage_one_reg;
        end
      end
      assign sync_out[i] = stage_two_reg ^ reset_level[i];
    end
  endgenerate
endmodule // pin_sync

/* verilog/host_bus_attachment_port.sv */
// host bus attachment port: master/slave muxed bus with apb control
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module host_bus_attachment_port
  import host_port_pkg::*;
#(
  parameter int SLAVE_WAIT = SLAVE_WAIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] muxed_addr_data_lines_i,
  output logic [31:0] muxed_addr_data_lines_o,
  output logic muxed_addr_data_lines_oe,
  input wire logic addr_strobe_inverted_i,
  output logic addr_strobe_inverted_o,
  output logic addr_strobe_inverted_oe,
  input wire logic data_cycle_strobe_n_i,
  output logic data_cycle_strobe_n_o,
  output logic data_cycle_strobe_n_oe,
  input wire logic read_write_i,
  output logic read_write_o,
  output logic read_write_oe,
  input wire logic mastership_claim_n_i,
  output logic mastership_claim_n_o,
  output logic mastership_claim_n_oe,
  output logic master_ind_n_o,
  output logic master_ind_n_oe,
  output logic bus_req_out_o,
  output logic bus_req_out_oe,
  input wire logic bus_grant_in,
  input wire logic hold_grant_in,
  input wire logic transfer_ack_low_i,
  output logic transfer_ack_low_o,
  output logic transfer_ack_low_oe,
  input wire logic chip_select_n,
  input wire logic port_kind,
  input wire logic collision_in,
  input wire logic carrier_sense_in,
  output logic xcvr_inbound_enable,
  output logic xcvr_outbound_enable
);
  // ----------------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------------
  initial begin
    if (SLAVE_WAIT < 1 || SLAVE_WAIT > 15) $error("slave wait must be 1 to 15");
  end

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  logic [SYNC_PINS-1:0] pins_raw;
  logic [SYNC_PINS-1:0] pins_idle;
  logic [SYNC_PINS-1:0] pins_s;
  assign pins_raw = {muxed_addr_data_lines_i, addr_strobe_inverted_i,
                     data_cycle_strobe_n_i, read_write_i, mastership_claim_n_i,
                     bus_grant_in, hold_grant_in, transfer_ack_low_i,
                     chip_select_n, port_kind};
  // active-low pins idle high so nothing looks asserted just after reset
  assign pins_idle = {32'h0000_0000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
                      1'b1, 1'b1, 1'b0};

  pin_sync #(.WIDTH(SYNC_PINS)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins_raw),
    .reset_level(pins_idle),
    .sync_out(pins_s)
  );

  logic [1:0] misc_s;
  pin_sync #(.WIDTH(2)) u_sync_net (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({collision_in, carrier_sense_in}),
    .reset_level(2'b00),
    .sync_out(misc_s)
  );

  wire [31:0] lines_s = pins_s[40:9];
  wire as_s = pins_s[8];
  wire dcs_n_s = pins_s[7];
  wire rw_s = pins_s[6];
  wire claim_n_s = pins_s[5];
  wire grant_s = pins_s[4];
  wire hold_s = pins_s[3];
  wire ack_n_s = pins_s[2];
  wire cs_n_s = pins_s[1];
  wire port_s = pins_s[0];

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic [31:0] slv_addr_reg;
  logic [31:0] slv_data_reg;
  logic [31:0] prdata_reg;
  logic write_dir_reg;
  master_state_e state_reg;
  master_state_e state_next;

  wire latch_polarity_bit = ctrl_reg[LATCH_POL_POS];
  wire serial_port_choice = ctrl_reg[PORT_CHOICE_POS];
  wire [1:0] bus_style_select = ctrl_reg[STYLE_LSB+:2];
  wire [1:0] byte_bank_select = ctrl_reg[BANK_SEL_LSB+:2];
  wire style_hold = (bus_style_select == STYLE_HOLD);
  wire style_grant = (bus_style_select == STYLE_GRANT);

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  wire setup = psel && !penable;
  wire wr_access = psel && penable && pwrite;
  wire hit_ctrl = (paddr == CTRL_OFFSET);
  wire hit_cmd = (paddr == CMD_OFFSET);
  wire hit_addr = (paddr == ADDR_OFFSET);
  wire hit_wdata = (paddr == WDATA_OFFSET);
  wire hit_rdata = (paddr == RDATA_OFFSET);
  wire hit_status = (paddr == STATUS_OFFSET);
  wire hit_slv_addr = (paddr == SLV_ADDR_OFFSET);
  wire hit_slv_data = (paddr == SLV_DATA_OFFSET);
  wire mapped = hit_ctrl | hit_cmd | hit_addr | hit_wdata | hit_rdata |
                hit_status | hit_slv_addr | hit_slv_data;
  wire busy = (state_reg != ST_IDLE);
  // a start while busy is dropped; software polls the busy bit first
  wire start = wr_access && hit_cmd && pwdata[CMD_START_POS] && !busy;
  // style is frozen during a transfer so the arbitration cannot change shape
  wire ctrl_wr = wr_access && hit_ctrl && !busy;

  wire owner = (state_reg == ST_ADDR) || (state_reg == ST_DATA) ||
               (state_reg == ST_DONE);
  wire coll_used = serial_port_choice ? misc_s[1] : 1'b0;
  wire carrier = misc_s[0];

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_BUSY_POS] = busy;
    status_word[ST_OWNER_POS] = owner;
    status_word[ST_COLL_POS] = coll_used;
    status_word[ST_CARRIER_POS] = carrier;
    status_word[ST_STATE_LSB+:3] = state_reg;
  end

  wire [31:0] read_mux = hit_ctrl ? ctrl_reg :
                         hit_addr ? addr_reg :
                         hit_wdata ? wdata_reg :
                         hit_rdata ? rdata_reg :
                         hit_status ? status_word :
                         hit_slv_addr ? slv_addr_reg :
                         hit_slv_data ? slv_data_reg : 32'h0000_0000;

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= DATA_RESET;
    end else if (setup) begin
      prdata_reg <= read_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      addr_reg <= DATA_RESET;
      wdata_reg <= DATA_RESET;
      write_dir_reg <= 1'b0;
    end else begin
      if (ctrl_wr) ctrl_reg <= pwdata;
      if (wr_access && hit_addr && !busy) addr_reg <= pwdata;
      if (wr_access && hit_wdata && !busy) wdata_reg <= pwdata;
      if (start) write_dir_reg <= pwdata[CMD_WRITE_POS];
    end
  end

  // ----------------------------------------------------------------------------
  // master state machine
  // ----------------------------------------------------------------------------
  // address strobe counts as idle when it sits at its inactive level
  wire as_idle = (as_s == latch_polarity_bit);
  wire bus_quiet = claim_n_s && dcs_n_s && as_idle;
  // hold grant drop: two sync flops plus one state edge stay within five
  wire preempted = style_hold && !hold_s;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) state_next = ST_REQ;
      end
      ST_REQ: begin
        if (style_hold && hold_s) state_next = ST_ADDR;
        if (style_grant && grant_s && bus_quiet) state_next = ST_ADDR;
      end
      ST_ADDR: begin
        state_next = preempted ? ST_IDLE : ST_DATA;
      end
      ST_DATA: begin
        if (preempted) state_next = ST_IDLE;
        else if (!ack_n_s) state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= DATA_RESET;
    end else if (state_reg == ST_DATA && !ack_n_s && !write_dir_reg && !preempted) begin
      rdata_reg <= lines_s;
    end
  end

  // ----------------------------------------------------------------------------
  // slave side
  // ----------------------------------------------------------------------------
  // select is masked while we own the bus; port kind is left unmasked and only acts through it
  wire slave_sel = !owner && !cs_n_s && !dcs_n_s;
  wire reg_port = port_s;
  logic slave_sel_q;
  logic [3:0] wait_cnt_reg;
  wire slave_start = slave_sel && !slave_sel_q;
  // ready only once the wait count has been loaded and run down
  wire slave_ready = slave_sel && slave_sel_q && (wait_cnt_reg == 4'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_sel_q <= 1'b0;
      wait_cnt_reg <= 4'h0;
    end else begin
      slave_sel_q <= slave_sel;
      if (slave_start) wait_cnt_reg <= 4'(SLAVE_WAIT);
      else if (slave_sel && wait_cnt_reg != 4'h0) wait_cnt_reg <= wait_cnt_reg - 4'h1;
    end
  end

  // write data is taken when the wait ends; the host holds it until acknowledged
  wire slave_wr_take = slave_sel && !rw_s && (wait_cnt_reg == 4'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slv_addr_reg <= DATA_RESET;
      slv_data_reg <= DATA_RESET;
    end else if (slave_wr_take) begin
      if (reg_port) slv_addr_reg <= lines_s;
      else slv_data_reg <= lines_s;
    end
  end

  wire slave_read = slave_sel && rw_s;

  // ----------------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------------
  wire in_addr = (state_reg == ST_ADDR);
  wire in_data = (state_reg == ST_DATA);
  wire [1:0] low_addr = style_hold ? byte_bank_select : addr_reg[1:0];
  wire [31:0] addr_word = {addr_reg[31:2], low_addr};
  wire [31:0] slave_word = reg_port ? slv_addr_reg : slv_data_reg;

  assign muxed_addr_data_lines_o = in_addr ? addr_word :
                                   owner ? wdata_reg : slave_word;
  assign muxed_addr_data_lines_oe = in_addr || (in_data && write_dir_reg) ||
                                    slave_read;
  assign addr_strobe_inverted_o = in_addr ^ latch_polarity_bit;
  assign addr_strobe_inverted_oe = owner;
  assign data_cycle_strobe_n_o = !in_data;
  assign data_cycle_strobe_n_oe = owner;
  assign read_write_o = !write_dir_reg;
  assign read_write_oe = owner;
  assign mastership_claim_n_o = 1'b0;
  assign mastership_claim_n_oe = owner && style_grant;
  assign master_ind_n_o = 1'b0;
  assign master_ind_n_oe = owner && style_hold;
  assign bus_req_out_o = 1'b1;
  assign bus_req_out_oe = (state_reg == ST_REQ) || (owner && style_hold);
  // low drive marks ready; released wait count keeps the line waiting
  assign transfer_ack_low_o = 1'b0;
  assign transfer_ack_low_oe = slave_ready;
  assign xcvr_inbound_enable = (in_data && !write_dir_reg) ||
                               (slave_sel && !rw_s);
  assign xcvr_outbound_enable = in_addr || (in_data && write_dir_reg) ||
                                slave_read;
endmodule // host_bus_attachment_port

/* test/host_port_asserts.sv */
// concurrent checks on the pins of the host bus attachment port
`timescale 1ns/10ps
module host_port_asserts #(
  parameter int SLAVE_WAIT = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic muxed_addr_data_lines_oe,
  input wire logic addr_strobe_inverted_o,
  input wire logic addr_strobe_inverted_oe,
  input wire logic data_cycle_strobe_n_i,
  input wire logic data_cycle_strobe_n_o,
  input wire logic data_cycle_strobe_n_oe,
  input wire logic read_write_oe,
  input wire logic mastership_claim_n_o,
  input wire logic mastership_claim_n_oe,
  input wire logic master_ind_n_oe,
  input wire logic bus_req_out_oe,
  input wire logic hold_grant_in,
  input wire logic transfer_ack_low_i,
  input wire logic transfer_ack_low_o,
  input wire logic transfer_ack_low_oe,
  input wire logic chip_select_n,
  input wire logic xcvr_inbound_enable,
  input wire logic xcvr_outbound_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_owner_flag: assert property (addr_strobe_inverted_oe |->
    (mastership_claim_n_oe ^ master_ind_n_oe)) else $error("owner flag wrong");
  a_claim_low: assert property (mastership_claim_n_oe |->
    !mastership_claim_n_o) else $error("claim not driven low");
  a_strobe_phase: assert property ($fell(data_cycle_strobe_n_o) && data_cycle_strobe_n_oe
    |-> $past(addr_strobe_inverted_oe) && $changed(addr_strobe_inverted_o))
    else $error("data phase without address strobe");
  a_data_wait: assert property ((data_cycle_strobe_n_oe && !data_cycle_strobe_n_o
    && transfer_ack_low_i && hold_grant_in)[*3] |=> !data_cycle_strobe_n_o)
    else $error("data phase ended without acknowledge");
  a_req_drop: assert property ($fell(hold_grant_in) && addr_strobe_inverted_oe
    |-> ##[1:5] !bus_req_out_oe) else $error("request held after preemption");
  a_float_idle: assert property (!addr_strobe_inverted_oe |->
    !data_cycle_strobe_n_oe && !read_write_oe) else $error("strobe driven when idle");
  // slave select reaches the logic through two sync flops
  a_lines_drive: assert property (muxed_addr_data_lines_oe |->
    addr_strobe_inverted_oe || ($past(!chip_select_n, 2) && $past(!data_cycle_strobe_n_i, 2)))
    else $error("lines driven when idle");
  a_out_path: assert property (muxed_addr_data_lines_oe |->
    xcvr_outbound_enable && !xcvr_inbound_enable) else $error("transceiver path wrong");
  // five samples: two sync flops, the start edge and the default single wait
  a_slave_ack: assert property ((!chip_select_n && !data_cycle_strobe_n_i
    && !bus_req_out_oe && !addr_strobe_inverted_oe)[*5] |-> transfer_ack_low_oe
    && !transfer_ack_low_o) else $error("slave access not acknowledged");
endmodule // host_port_asserts

/* test/bus_mem.sv */
// partner model: memory target and bus arbiter beyond the host bus
`timescale 1ns/10ps
module bus_mem #(
  parameter logic [31:0] RD = 32'h0000_0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic strobe_on,
  input wire logic rd,
  input wire logic stall,
  input wire logic slow,
  output logic grant,
  output logic ack,
  output logic [31:0] md,
  output logic moe
);
  logic [1:0] cnt;
  assign md = RD;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant <= 1'b0;
      ack <= 1'b0;
      cnt <= 2'h0;
      moe <= 1'b0;
    end else begin
      grant <= req;
      cnt <= strobe_on ? cnt + {1'b0, cnt != 2'h3} : 2'h0;
      // slow mode inserts wait states; stall never answers
      ack <= strobe_on && !stall && (ack || !slow || cnt == 2'h3);
      moe <= strobe_on && rd;
    end
  end
endmodule // bus_mem

/* test/tb.sv */
// self-checking bench for the host bus attachment port
`timescale 1ns/10ps
module tb;
  import host_port_pkg::*;
  localparam logic [31:0] MEM_WORD = 32'h5a3c_96e1;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err, idle_as, mack, moe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, host_d, md, muxed_addr_data_lines_i, muxed_addr_data_lines_o;
  logic muxed_addr_data_lines_oe, addr_strobe_inverted_i, addr_strobe_inverted_o;
  logic addr_strobe_inverted_oe, data_cycle_strobe_n_i, data_cycle_strobe_n_o;
  logic data_cycle_strobe_n_oe, read_write_i, read_write_o, read_write_oe;
  logic mastership_claim_n_i, mastership_claim_n_o, mastership_claim_n_oe;
  logic master_ind_n_o, master_ind_n_oe, bus_req_out_o, bus_req_out_oe, bus_grant_in;
  logic hold_grant_in, transfer_ack_low_i, transfer_ack_low_o, transfer_ack_low_oe;
  logic chip_select_n, port_kind, collision_in, carrier_sense_in, xcvr_inbound_enable;
  logic xcvr_outbound_enable, host_dcs_n, host_rw, other_claim, hold_ok, stall, slow;
  int error_cnt, checked, cyc;
  host_bus_attachment_port dut (.*);
  bus_mem #(.RD(MEM_WORD)) mem (.pclk(pclk), .presetn(presetn), .req(bus_req_out_oe),
    .strobe_on(data_cycle_strobe_n_oe && !data_cycle_strobe_n_o), .rd(read_write_o),
    .stall(stall), .slow(slow), .grant(bus_grant_in), .ack(mack), .md(md), .moe(moe));
  // ----
  // pin resolution: released lines show the memory word while it drives, else the host pattern, not the last value
  // ----
  assign muxed_addr_data_lines_i = muxed_addr_data_lines_oe ? muxed_addr_data_lines_o
    : moe ? md : host_d;
  assign addr_strobe_inverted_i = addr_strobe_inverted_oe ? addr_strobe_inverted_o : idle_as;
  assign data_cycle_strobe_n_i = data_cycle_strobe_n_oe ? data_cycle_strobe_n_o : host_dcs_n;
  assign read_write_i = read_write_oe ? read_write_o : host_rw;
  assign mastership_claim_n_i = !(mastership_claim_n_oe || other_claim);
  assign transfer_ack_low_i = !((transfer_ack_low_oe && !transfer_ack_low_o) || mack);
  assign hold_grant_in = bus_grant_in && hold_ok;
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_master(input logic [1:0] s, input logic p, input logic w);
    logic [31:0] a, r, seen, dw;
    logic cl, mi, xo, xi, got;
    int n;
    a = 32'h8a4c_2e00 | {27'h0, s[0], p, w, ~w, p};
    got = 1'b0;
    n = 0;
    idle_as <= p;
    slow <= w;
    apb(1'b1, CTRL_OFFSET, (32'(p) << LATCH_POL_POS) | (32'(s) << STYLE_LSB)
      | (32'h2 << BANK_SEL_LSB), r);
    apb(1'b1, ADDR_OFFSET, a, r);
    apb(1'b1, WDATA_OFFSET, ~a, r);
    apb(1'b1, CMD_OFFSET, {30'h0, w, 1'b1}, r);
    while (n < 60 && !(got && !addr_strobe_inverted_oe)) begin
      @(negedge pclk);
      n++;
      if (!got && addr_strobe_inverted_oe && addr_strobe_inverted_o === !p) begin
        got = 1'b1;
        seen = muxed_addr_data_lines_o;
        cl = mastership_claim_n_oe;
        mi = master_ind_n_oe;
        xo = xcvr_outbound_enable;
      end
      if (data_cycle_strobe_n_oe && !data_cycle_strobe_n_o) begin
        dw = muxed_addr_data_lines_i;
        xi = xcvr_inbound_enable;
      end
    end
    @(posedge pclk);
    chk("address strobe", got, 1);
    chk("address phase", seen, {a[31:2], s[0] ? a[1:0] : 2'b10});
    chk("claim", cl, s[0]);
    chk("master ind", mi, !s[0]);
    chk("outbound", xo, 1);
    chk("data phase", dw, w ? ~a : MEM_WORD);
    chk("inbound", xi, !w);
    apb(1'b0, RDATA_OFFSET, 0, r);
    if (!w) chk("read data", r, MEM_WORD);
    apb(1'b0, STATUS_OFFSET, 0, r);
    chk("busy", r[ST_BUSY_POS], 0);
    $display("master style %0d pol %0d write %0d done", s, p, w);
  endtask
  task automatic t_claim(input int k);
    logic [31:0] r;
    logic own;
    int n;
    own = 1'b0;
    n = 0;
    slow <= 1'b0;
    idle_as <= (k == 1);
    other_claim <= (k == 0);
    host_dcs_n <= (k != 2);
    apb(1'b1, CTRL_OFFSET, 32'h1 << STYLE_LSB, r);
    apb(1'b1, CMD_OFFSET, 32'h1, r);
    repeat (20) begin
      @(negedge pclk);
      own = own | addr_strobe_inverted_oe | mastership_claim_n_oe;
    end
    chk("owner while bus busy", own, 0);
    @(posedge pclk);
    idle_as <= 1'b0;
    other_claim <= 1'b0;
    host_dcs_n <= 1'b1;
    while (n < 20 && addr_strobe_inverted_oe !== 1'b1) begin
      @(negedge pclk);
      n++;
    end
    chk("owner after idle", addr_strobe_inverted_oe, 1);
    while (n < 60 && addr_strobe_inverted_oe) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    $display("claim blocker %0d done", k);
  endtask
  task automatic t_preempt();
    logic [31:0] r;
    int n;
    n = 0;
    idle_as <= 1'b0;
    stall <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h0, r);
    apb(1'b1, CMD_OFFSET, 32'h1, r);
    while (n < 30 && data_cycle_strobe_n_o !== 1'b0) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    hold_ok <= 1'b0;
    n = 0;
    while (n < 10 && bus_req_out_oe !== 1'b0) begin
      @(negedge pclk);
      n++;
    end
    chk("request drop", n <= 5, 1);
    chk("released", {muxed_addr_data_lines_oe, addr_strobe_inverted_oe}, 0);
    @(posedge pclk);
    stall <= 1'b0;
    hold_ok <= 1'b1;
    $display("preempt done");
  endtask
  task automatic slv(input logic k, input logic w, input logic [31:0] v,
    output logic [31:0] r);
    int n;
    n = 0;
    chip_select_n <= 1'b0;
    port_kind <= k;
    host_rw <= !w;
    host_d <= v;
    host_dcs_n <= 1'b0;
    do begin
      @(negedge pclk);
      n++;
    end while (n < 20 && transfer_ack_low_oe !== 1'b1);
    r = muxed_addr_data_lines_o;
    chk("slave ack", transfer_ack_low_oe, 1);
    if (!w) chk("slave drive", muxed_addr_data_lines_oe, 1);
    @(posedge pclk);
    chip_select_n <= 1'b1;
    host_dcs_n <= 1'b1;
    host_d <= ~v;
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_slave();
    logic [31:0] r;
    slv(1'b1, 1'b1, 32'h0000_0c2c, r);
    slv(1'b0, 1'b1, 32'hb7e1_5163, r);
    apb(1'b0, SLV_ADDR_OFFSET, 0, r);
    chk("address port", r, 32'h0000_0c2c);
    apb(1'b0, SLV_DATA_OFFSET, 0, r);
    chk("data port", r, 32'hb7e1_5163);
    slv(1'b1, 1'b0, 0, r);
    chk("address port read", r, 32'h0000_0c2c);
    slv(1'b0, 1'b0, 0, r);
    chk("data port read", r, 32'hb7e1_5163);
    $display("slave done");
  endtask
  task automatic t_coll();
    logic [31:0] r;
    collision_in <= 1'b1;
    carrier_sense_in <= 1'b1;
    apb(1'b0, 8'h24, 0, r);
    chk("unmapped error", last_err, 1);
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, CTRL_OFFSET, 32'(b) << PORT_CHOICE_POS, r);
      repeat (3) @(posedge pclk);
      apb(1'b0, STATUS_OFFSET, 0, r);
      chk("collision used", r[ST_COLL_POS], b[0]);
      chk("carrier", r[ST_CARRIER_POS], 1);
    end
    $display("collision done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, host_d} = '0;
    {collision_in, carrier_sense_in, port_kind, host_rw, other_claim, stall, slow} = '0;
    {chip_select_n, host_dcs_n, hold_ok, idle_as} = 4'hf;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_coll();
    for (int i = 0; i < 8; i++) t_master(2'(i >> 2), i[1], i[0]);
    for (int k = 0; k < 3; k++) t_claim(k);
    t_preempt();
    t_slave();
    wrap_up();
  end
endmodule // tb
bind host_bus_attachment_port host_port_asserts #(.SLAVE_WAIT(SLAVE_WAIT)) chk (.*);
